// file: core/lpsd_pin_if.sv
// Purpose: Pin-level control front end of a four-bank low-power SDR SDRAM.
// Assumes: Pins arrive from another clock domain and pass two flip-flops first.
// Notes: The array itself sits outside; this block decodes, masks and tracks state.
// How it works
// R1: Every input pin is captured only on the rising edge of the system clock.
// R2: Each enabled clock edge advances the burst column counter and loads the output data register; here the counter steps only in bursts, dq_o on rd_valid.
// R3: Clock gate high lets the internal clock run and low stops it, the resulting state depending on the banks.
// R4: Gate low with banks idle gives precharge power-down, self refresh or deep power-down, open row gives active power-down, a burst gives suspend.
// R5: The gate is synchronous except from entry to exit of power-down and self refresh, where it is seen asynchronously; here it always passes both sync stages.
// R6: In power-down and self refresh the input buffers, clock buffer included, are switched off.
// R7: Strobes are decoded only when chip select is registered low, and all commands are ignored when it is high.
// R8: The command comes jointly from chip select and the three strobes sampled on one edge.
// R9: A byte mask sampled high during a write keeps that byte out of the array.
// R10: A byte mask sampled high during a read turns that byte's drivers off two clocks later.
// R11: In the 32-bit form lane masks 0 to 3 govern bytes 7:0, 15:8, 23:16 and 31:24.
// R12: The two bank select lines pick the bank of an activate, read, write or single precharge.
// R13: A precharge with the precharge-all bit high ignores bank select and closes every bank.
// R14: Activate takes the address as row, read and write as column with the auto-precharge bit, precharge as bank choice.
// R15: In the 16-bit form the low mask governs bits 7:0 and the high mask bits 15:8.
// R16: Commands follow the usual SDR truth table over the four strobes.
// R17: The controller asserts read masks two clocks ahead of the data it wants suppressed.
`timescale 1ns/1ns
module lpsd_pin_if #(
  parameter int unsigned DQ_W = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Controller pins.
  input wire logic clock_gate,
  input wire lpsd_pkg::lpsd_cmd_pins_t cmd_pins,
  input wire logic [lpsd_pkg::LPSD_BANK_W-1:0] bank_select,
  input wire logic [lpsd_pkg::LPSD_ADDR_W-1:0] addr,
  input wire logic [DQ_W/8-1:0] byte_mask,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W/8-1:0] dq_oe,
  // Low-power requests that pick the idle state.
  input wire logic self_ref_req,
  input wire logic deep_pd_req,
  // Array side.
  input wire logic [DQ_W-1:0] rd_data,
  input wire logic rd_valid,
  output lpsd_pkg::lpsd_cmd_t cmd,
  output logic [lpsd_pkg::LPSD_COL_W-1:0] burst_col,
  output logic [DQ_W-1:0] wr_data,
  output logic [DQ_W/8-1:0] wr_byte_en,
  output logic wr_valid,
  output logic [lpsd_pkg::LPSD_BANKS-1:0] open_banks,
  output lpsd_pkg::lpsd_pwr_t pwr_state,
  output logic in_buf_en
);
  localparam int unsigned NB = DQ_W / 8;
  localparam int unsigned SW = $bits(lpsd_pkg::lpsd_cmd_pins_t) + lpsd_pkg::LPSD_BANK_W + lpsd_pkg::LPSD_ADDR_W + NB + DQ_W + 2;
  // Stages start deselected with the gate high, so leaving reset does not look like a power-down request.
  localparam logic [SW-1:0] S_IDLE = {1'b1, {(SW - 3){1'b0}}, 2'h2};

  initial begin
    if (DQ_W != 16 && DQ_W != 32) begin
      $error("DQ_W must be 16 or 32.");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    lpsd_pkg::lpsd_cmd_t cmd;
    logic [lpsd_pkg::LPSD_COL_W-1:0] col;
    logic burst;
    logic burst_rd;
    logic [DQ_W-1:0] dq_o;
    logic [NB-1:0] mask_d1;
    logic [NB-1:0] oe;
    logic [DQ_W-1:0] wr_data;
    logic [NB-1:0] wr_be;
    logic wr_valid;
    logic [lpsd_pkg::LPSD_BANKS-1:0] open;
    lpsd_pkg::lpsd_pwr_t pwr;
    logic in_buf_en;
  } lpsd_st_t;

  lpsd_st_t st_q;
  lpsd_st_t st_d;

  // Second synchroniser stage fields.
  lpsd_pkg::lpsd_cmd_pins_t p_cmd;
  logic [lpsd_pkg::LPSD_BANK_W-1:0] p_ba;
  logic [lpsd_pkg::LPSD_ADDR_W-1:0] p_addr;
  logic [NB-1:0] p_mask;
  logic [DQ_W-1:0] p_dq;
  logic p_cke;
  logic p_sr;
  assign {p_cmd, p_ba, p_addr, p_mask, p_dq, p_cke, p_sr} = st_q.s2;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] code;
    logic run;
    logic [lpsd_pkg::LPSD_BANKS-1:0] sel;
    code = 3'h0;
    run = 1'b0;
    sel = '0;
    st_d = st_q;
    // Only the gate and the self-refresh request keep being sampled while the buffers are off, so the gate can wake the part. [R5]
    st_d.s1 = {cmd_pins, bank_select, addr, byte_mask, dq_i, clock_gate, self_ref_req};
    if (!st_q.in_buf_en) begin
      st_d.s1 = {st_q.s1[SW-1:2], clock_gate, self_ref_req};
    end
    st_d.s2 = st_q.s1; // [R1]
    st_d.cmd.op = lpsd_pkg::LPSD_OP_NONE;
    st_d.cmd.auto_pre = 1'b0;
    st_d.wr_valid = 1'b0;
    run = (st_q.pwr == lpsd_pkg::LPSD_RUN) && p_cke; // [R3]
    unique case (st_q.pwr)
      lpsd_pkg::LPSD_RUN: begin
        if (!p_cke) begin
          // Gate low picks the state from bank and burst status. [R4]
          if (st_q.burst) begin
            st_d.pwr = lpsd_pkg::LPSD_SUSPEND;
          end else if (st_q.open != '0) begin
            st_d.pwr = lpsd_pkg::LPSD_ACT_PD;
          end else if (deep_pd_req) begin
            st_d.pwr = lpsd_pkg::LPSD_DEEP_PD;
          end else if (p_sr) begin
            st_d.pwr = lpsd_pkg::LPSD_SELF_REF;
          end else begin
            st_d.pwr = lpsd_pkg::LPSD_PRE_PD;
          end
        end
      end
      lpsd_pkg::LPSD_SUSPEND: begin
        if (p_cke) begin
          st_d.pwr = lpsd_pkg::LPSD_RUN;
        end
      end
      default: begin
        if (p_cke) begin
          st_d.pwr = lpsd_pkg::LPSD_RUN;
        end
      end
    endcase
    // Buffers off in power-down and self refresh only, suspend keeps them. [R6]
    st_d.in_buf_en = (st_d.pwr == lpsd_pkg::LPSD_RUN) || (st_d.pwr == lpsd_pkg::LPSD_SUSPEND);
    if (run) begin
      sel = '0;
      sel[p_ba] = 1'b1; // [R12]
      code = {p_cmd.ras_n, p_cmd.cas_n, p_cmd.we_n}; // [R8]
      st_d.cmd.banks = sel;
      st_d.cmd.addr = p_addr;
      if (!p_cmd.cs_n) begin // [R7]
        unique case (code) // [R16]
          lpsd_pkg::LPSD_CMD_ACT: begin
            st_d.cmd.op = lpsd_pkg::LPSD_OP_ACT; // [R14]
            st_d.open = st_q.open | sel;
          end
          lpsd_pkg::LPSD_CMD_RD, lpsd_pkg::LPSD_CMD_WR: begin
            st_d.cmd.op = (code == lpsd_pkg::LPSD_CMD_RD) ? lpsd_pkg::LPSD_OP_RD : lpsd_pkg::LPSD_OP_WR;
            st_d.cmd.auto_pre = p_addr[lpsd_pkg::LPSD_PALL_BIT]; // [R14]
            st_d.col = p_addr[lpsd_pkg::LPSD_COL_W-1:0];
            st_d.burst = 1'b1;
            st_d.burst_rd = (code == lpsd_pkg::LPSD_CMD_RD);
          end
          lpsd_pkg::LPSD_CMD_PRE: begin
            st_d.cmd.op = lpsd_pkg::LPSD_OP_PRE;
            if (p_addr[lpsd_pkg::LPSD_PALL_BIT]) begin
              st_d.cmd.banks = '1; // [R13]
              st_d.open = '0;
            end else begin
              st_d.open = st_q.open & ~sel;
            end
          end
          lpsd_pkg::LPSD_CMD_REF: st_d.cmd.op = lpsd_pkg::LPSD_OP_REF;
          lpsd_pkg::LPSD_CMD_MRS: st_d.cmd.op = lpsd_pkg::LPSD_OP_MRS;
          lpsd_pkg::LPSD_CMD_BST: begin
            st_d.cmd.op = lpsd_pkg::LPSD_OP_BST;
            st_d.burst = 1'b0;
          end
          lpsd_pkg::LPSD_CMD_NOP: st_d.cmd.op = lpsd_pkg::LPSD_OP_NONE;
        endcase
      end
      if (st_q.burst && (p_cmd.cs_n || code == lpsd_pkg::LPSD_CMD_NOP)) begin
        st_d.col = st_q.col + 1'b1; // [R2]
      end
      if (st_q.burst && !st_q.burst_rd) begin
        // Masked write lanes are left out of the byte enables. [R9] [R11] [R15]
        st_d.wr_data = p_dq;
        st_d.wr_be = ~p_mask;
        st_d.wr_valid = 1'b1;
      end
      if (rd_valid) begin
        st_d.dq_o = rd_data; // [R2]
      end
      // Read mask is delayed one extra stage to give the two-clock latency. [R10] [R17]
      // Drivers stay off once a read burst has been terminated.
      st_d.mask_d1 = p_mask;
      st_d.oe = (st_q.burst && st_q.burst_rd) ? ~st_q.mask_d1 : '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.s1 <= S_IDLE;
      st_q.s2 <= S_IDLE;
      st_q.in_buf_en <= 1'b1;
      st_q.pwr <= lpsd_pkg::LPSD_RUN;
      st_q.cmd.op <= lpsd_pkg::LPSD_OP_NONE;
    end else begin
      st_q <= st_d; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dq_o = st_q.dq_o;
  assign dq_oe = st_q.oe;
  assign cmd = st_q.cmd;
  assign burst_col = st_q.col;
  assign wr_data = st_q.wr_data;
  assign wr_byte_en = st_q.wr_be;
  assign wr_valid = st_q.wr_valid;
  assign open_banks = st_q.open;
  assign pwr_state = st_q.pwr;
  assign in_buf_en = st_q.in_buf_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic run_q;
  assign run_q = (st_q.pwr == lpsd_pkg::LPSD_RUN) && p_cke;

  cs_masks_a: assert property (@(posedge clk) disable iff (rst) // [R7]
    (p_cmd.cs_n && st_q.pwr == lpsd_pkg::LPSD_RUN) |=> cmd.op == lpsd_pkg::LPSD_OP_NONE)
    else $error("Command decoded with chip select high.");
  pre_all_a: assert property (@(posedge clk) disable iff (rst) // [R13]
    (cmd.op == lpsd_pkg::LPSD_OP_PRE && cmd.addr[lpsd_pkg::LPSD_PALL_BIT]) |-> open_banks == '0)
    else $error("Precharge all left a bank open.");
  act_opens_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    cmd.op == lpsd_pkg::LPSD_OP_ACT |-> (open_banks & cmd.banks) == cmd.banks)
    else $error("Activate did not open its bank.");
  wr_mask_a: assert property (@(posedge clk) disable iff (rst) // [R9]
    wr_valid |-> wr_byte_en == ~$past(p_mask))
    else $error("Write mask not applied.");
  rd_mask_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    ($past(run_q) && $past(run_q, 2) && $past(st_q.burst && st_q.burst_rd)) |-> dq_oe == ~$past(p_mask, 2))
    else $error("Read mask latency wrong.");
  suspend_entry_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    (st_q.pwr == lpsd_pkg::LPSD_RUN && !p_cke && st_q.burst) |=> pwr_state == lpsd_pkg::LPSD_SUSPEND)
    else $error("Burst did not enter suspend.");
  buf_off_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    (pwr_state == lpsd_pkg::LPSD_PRE_PD || pwr_state == lpsd_pkg::LPSD_SELF_REF) |-> !in_buf_en)
    else $error("Input buffers on in power-down.");
  col_step_a: assert property (@(posedge clk) disable iff (rst) // [R2]
    (run_q && st_q.burst && (p_cmd.cs_n || {p_cmd.ras_n, p_cmd.cas_n, p_cmd.we_n} == lpsd_pkg::LPSD_CMD_NOP))
      |=> burst_col == $past(burst_col) + 1'b1)
    else $error("Burst counter did not advance.");
  wake_a: assert property (@(posedge clk) disable iff (rst) // [R5]
    (pwr_state != lpsd_pkg::LPSD_RUN && clock_gate) |-> ##[1:3] pwr_state == lpsd_pkg::LPSD_RUN)
    else $error("Gate high did not wake the part.");

  oe_idle_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    ($past(run_q) && !$past(st_q.burst && st_q.burst_rd)) |-> dq_oe == '0)
    else $error("Drivers on outside a read burst.");
  no_decode_pd_a: assert property (@(posedge clk) disable iff (rst) // [R3]
    st_q.pwr != lpsd_pkg::LPSD_RUN |=> cmd.op == lpsd_pkg::LPSD_OP_NONE)
    else $error("Command decoded while the clock was gated.");
  bank_onehot_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    (cmd.op == lpsd_pkg::LPSD_OP_ACT || cmd.op == lpsd_pkg::LPSD_OP_RD || cmd.op == lpsd_pkg::LPSD_OP_WR)
      |-> $onehot(cmd.banks))
    else $error("Bank access did not pick one bank.");
  pre_bank_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    (cmd.op == lpsd_pkg::LPSD_OP_PRE && !cmd.addr[lpsd_pkg::LPSD_PALL_BIT]) |-> (open_banks & cmd.banks) == '0)
    else $error("Single precharge left its bank open.");
  act_pd_entry_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    (st_q.pwr == lpsd_pkg::LPSD_RUN && !p_cke && !st_q.burst && st_q.open != '0) |=> pwr_state == lpsd_pkg::LPSD_ACT_PD)
    else $error("Open row did not enter active power-down.");
  idle_entry_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    (st_q.pwr == lpsd_pkg::LPSD_RUN && !p_cke && !st_q.burst && st_q.open == '0) |=> (pwr_state == lpsd_pkg::LPSD_PRE_PD
      || pwr_state == lpsd_pkg::LPSD_SELF_REF || pwr_state == lpsd_pkg::LPSD_DEEP_PD))
    else $error("Idle banks did not enter an idle low-power state.");
  pd_buf_off_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    (pwr_state == lpsd_pkg::LPSD_ACT_PD || pwr_state == lpsd_pkg::LPSD_DEEP_PD) |-> !in_buf_en)
    else $error("Input buffers on in power-down.");
  col_hold_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    pwr_state == lpsd_pkg::LPSD_SUSPEND |=> burst_col == $past(burst_col))
    else $error("Burst counter moved in suspend.");
  auto_pre_a: assert property (@(posedge clk) disable iff (rst) // [R14]
    (cmd.op == lpsd_pkg::LPSD_OP_RD || cmd.op == lpsd_pkg::LPSD_OP_WR) |-> cmd.auto_pre == cmd.addr[lpsd_pkg::LPSD_PALL_BIT])
    else $error("Auto precharge flag not taken from the address.");
  rd_col_a: assert property (@(posedge clk) disable iff (rst) // [R14]
    (cmd.op == lpsd_pkg::LPSD_OP_RD || cmd.op == lpsd_pkg::LPSD_OP_WR) |-> burst_col == cmd.addr[lpsd_pkg::LPSD_COL_W-1:0])
    else $error("Burst did not start at the given column.");

  // Every lane follows its own mask, two clocks late, while a read burst runs.
  for (genvar g = 0; g < NB; g++) begin : g_lane
    lane_oe_a: assert property (@(posedge clk) disable iff (rst) // [R10] [R11] [R15]
      ($past(run_q) && $past(run_q, 2) && $past(st_q.burst && st_q.burst_rd) && $past(p_mask[g], 2))
        |-> !dq_oe[g])
      else $error("Masked lane still driven.");
  end

  read_c: cover property (@(posedge clk) disable iff (rst) cmd.op == lpsd_pkg::LPSD_OP_RD);
  deep_pd_c: cover property (@(posedge clk) disable iff (rst) pwr_state == lpsd_pkg::LPSD_DEEP_PD);
  suspend_c: cover property (@(posedge clk) disable iff (rst) pwr_state == lpsd_pkg::LPSD_SUSPEND);
  self_ref_c: cover property (@(posedge clk) disable iff (rst) pwr_state == lpsd_pkg::LPSD_SELF_REF);
  masked_wr_c: cover property (@(posedge clk) disable iff (rst) wr_valid && wr_byte_en != '1);
endmodule

// file: dv/lpsd_ctrl_model.sv
// Purpose: Behavioural model of the memory controller that drives the pins.
// Assumes: Pins change just after a rising clock edge.
// Notes: Data lines not carrying a write beat show the inverse of the last value.
`timescale 1ns/1ns
module lpsd_ctrl_model (
  // Clock.
  input wire logic clk,
  // Pins toward the device.
  output lpsd_pkg::lpsd_cmd_pins_t cmd_pins,
  output logic clock_gate,
  output logic [1:0] bank_select,
  output logic [13:0] addr,
  output logic [3:0] byte_mask,
  output logic [31:0] dq_i
);
  initial begin
    cmd_pins = {1'b0, lpsd_pkg::LPSD_CMD_NOP};
    clock_gate = 1'b1;
    bank_select = 2'h0;
    addr = 14'h0000;
    byte_mask = 4'h0;
    dq_i = 32'h0000_0000;
  end

  // Mask is set with the command, one clock ahead of the write data it governs.
  task automatic issue(input logic cs_n, input logic [2:0] code, input logic [1:0] ba, input logic a10,
                       input logic [3:0] mask, input logic [31:0] data);
    @(posedge clk);
    cmd_pins <= {cs_n, code};
    bank_select <= ba;
    addr <= {3'h0, a10, 10'h005};
    byte_mask <= mask;
    @(posedge clk);
    cmd_pins <= {1'b0, lpsd_pkg::LPSD_CMD_NOP};
    bank_select <= ~ba;
    addr <= ~addr;
    dq_i <= data;
    @(posedge clk);
    dq_i <= ~data;
  endtask

  task automatic gate(input logic lvl);
    @(posedge clk);
    clock_gate <= lvl;
  endtask
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench of the SDRAM pin front end.
// Assumes: Design default width of 32 data bits.
// Notes: Each scenario is one task; waits are bounded.
`timescale 1ns/1ns
module tb;
  logic clk;
  logic rst;
  logic self_ref_req;
  logic deep_pd_req;
  logic [31:0] rd_data;
  logic rd_valid;
  logic clock_gate;
  lpsd_pkg::lpsd_cmd_pins_t cmd_pins;
  logic [1:0] bank_select;
  logic [13:0] addr;
  logic [3:0] byte_mask;
  logic [31:0] dq_i;
  int n_errors;
  int checked;

  lpsd_ctrl_model u_m (.clk(clk), .cmd_pins(cmd_pins), .clock_gate(clock_gate), .bank_select(bank_select),
                       .addr(addr), .byte_mask(byte_mask), .dq_i(dq_i));
  lpsd_pin_if DUT (.clk(clk), .rst(rst), .clock_gate(clock_gate), .cmd_pins(cmd_pins),
                   .bank_select(bank_select), .addr(addr), .byte_mask(byte_mask), .dq_i(dq_i), .dq_o(),
                   .dq_oe(), .self_ref_req(self_ref_req), .deep_pd_req(deep_pd_req), .rd_data(rd_data),
                   .rd_valid(rd_valid), .cmd(), .burst_col(), .wr_data(), .wr_byte_en(), .wr_valid(),
                   .open_banks(), .pwr_state(), .in_buf_en());

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_op(input lpsd_pkg::lpsd_op_t op);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (DUT.cmd.op === op) return;
    end
    chk(32'(DUT.cmd.op), 32'(op));
    summarize();
  endtask

  task automatic wait_pwr(input lpsd_pkg::lpsd_pwr_t st);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      if (DUT.pwr_state === st) return;
    end
    chk(32'(DUT.pwr_state), 32'(st));
    summarize();
  endtask

  task automatic t_act(input logic [1:0] ba);
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_ACT, ba, 1'b0, 4'h0, 32'h0);
    wait_op(lpsd_pkg::LPSD_OP_ACT);
    chk(32'(DUT.cmd.banks), 32'(4'h1 << ba));
    @(posedge clk);
    #1;
    chk(32'(DUT.open_banks[ba]), 32'h1);
  endtask

  task automatic t_cs_masked();
    u_m.issue(1'b1, lpsd_pkg::LPSD_CMD_ACT, 2'h1, 1'b0, 4'h0, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      chk(32'(DUT.cmd.op), 32'(lpsd_pkg::LPSD_OP_NONE));
    end
    chk(32'(DUT.open_banks[1]), 32'h0);
  endtask

  task automatic t_pre_all();
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_PRE, 2'h1, 1'b1, 4'h0, 32'h0);
    wait_op(lpsd_pkg::LPSD_OP_PRE);
    chk(32'(DUT.cmd.banks), 32'hf);
    @(posedge clk);
    #1;
    chk(32'(DUT.open_banks), 32'h0);
  endtask

  task automatic t_write();
    bit seen;
    seen = 0;
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_WR, 2'h0, 1'b0, 4'h5, 32'h1122_3344);
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (DUT.wr_valid === 1'b1);
    end
    chk(32'(seen), 32'h1);
    chk(32'(DUT.wr_byte_en), 32'ha);
    chk(DUT.wr_data & 32'hff00_ff00, 32'h1100_3300);
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_BST, 2'h0, 1'b0, 4'h0, 32'h0);
  endtask

  task automatic t_read();
    bit seen;
    seen = 0;
    rd_valid <= 1'b1;
    rd_data <= 32'h55aa_33cc;
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_RD, 2'h0, 1'b0, 4'h9, 32'h0);
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (DUT.dq_oe === 4'h6);
    end
    chk(32'(seen), 32'h1);
    chk(DUT.dq_o, 32'h55aa_33cc);
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_BST, 2'h0, 1'b0, 4'h0, 32'h0);
    wait_op(lpsd_pkg::LPSD_OP_BST);
    @(posedge clk);
    #1;
    chk(32'(DUT.dq_oe), 32'h0);
    rd_valid <= 1'b0;
  endtask

  task automatic t_suspend();
    logic [9:0] col;
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_RD, 2'h0, 1'b1, 4'h0, 32'h0);
    wait_op(lpsd_pkg::LPSD_OP_RD);
    chk(32'(DUT.burst_col), 32'h5);
    chk(32'(DUT.cmd.auto_pre), 32'h1);
    u_m.gate(1'b0);
    wait_pwr(lpsd_pkg::LPSD_SUSPEND);
    chk(32'(DUT.in_buf_en), 32'h1);
    col = DUT.burst_col;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(DUT.burst_col), 32'(col));
    u_m.gate(1'b1);
    wait_pwr(lpsd_pkg::LPSD_RUN);
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_BST, 2'h0, 1'b0, 4'h0, 32'h0);
  endtask

  task automatic t_pre_one(input logic [1:0] ba);
    u_m.issue(1'b0, lpsd_pkg::LPSD_CMD_PRE, ba, 1'b0, 4'h0, 32'h0);
    wait_op(lpsd_pkg::LPSD_OP_PRE);
    chk(32'(DUT.cmd.banks), 32'(4'h1 << ba));
    chk(32'(DUT.open_banks), 32'h0);
  endtask

  task automatic t_pwr(input logic sr, input logic dp, input lpsd_pkg::lpsd_pwr_t st);
    @(posedge clk);
    self_ref_req <= sr;
    deep_pd_req <= dp;
    u_m.gate(1'b0);
    wait_pwr(st);
    chk(32'(DUT.in_buf_en), 32'h0);
    u_m.gate(1'b1);
    wait_pwr(lpsd_pkg::LPSD_RUN);
    chk(32'(DUT.in_buf_en), 32'h1);
    self_ref_req <= 1'b0;
    deep_pd_req <= 1'b0;
  endtask

  initial begin
    n_errors = 0;
    checked = 0;
    rst = 1'b1;
    self_ref_req = 1'b0;
    deep_pd_req = 1'b0;
    rd_data = 32'h0;
    rd_valid = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_act(2'h2);
    t_cs_masked();
    t_pre_all();
    t_write();
    t_read();
    t_pre_all();
    t_pwr(1'b0, 1'b0, lpsd_pkg::LPSD_PRE_PD);
    t_pwr(1'b1, 1'b0, lpsd_pkg::LPSD_SELF_REF);
    t_pwr(1'b0, 1'b1, lpsd_pkg::LPSD_DEEP_PD);
    t_suspend();
    t_act(2'h0);
    t_pwr(1'b0, 1'b0, lpsd_pkg::LPSD_ACT_PD);
    t_pre_one(2'h0);
    summarize();
  end
endmodule

// file: inc/lpsd_pkg.sv
// Purpose: Shared constants and types of the low-power SDRAM pin interface.
// Assumes: Single clock at 10 MHz, four banks, SDR command set.
// Notes: Command codes are the strobe triple {row, column, write} active low.
package lpsd_pkg;
  localparam int unsigned LPSD_BANKS = 4;
  localparam int unsigned LPSD_BANK_W = 2;
  localparam int unsigned LPSD_ADDR_W = 14;
  localparam int unsigned LPSD_PALL_BIT = 10;
  localparam int unsigned LPSD_COL_W = 10;
  localparam int unsigned LPSD_DQM_LAT = 2;
  localparam logic [2:0] LPSD_CMD_MRS = 3'h0;
  localparam logic [2:0] LPSD_CMD_REF = 3'h1;
  localparam logic [2:0] LPSD_CMD_PRE = 3'h2;
  localparam logic [2:0] LPSD_CMD_ACT = 3'h3;
  localparam logic [2:0] LPSD_CMD_WR = 3'h4;
  localparam logic [2:0] LPSD_CMD_RD = 3'h5;
  localparam logic [2:0] LPSD_CMD_BST = 3'h6;
  localparam logic [2:0] LPSD_CMD_NOP = 3'h7;

  typedef enum logic [3:0] {
    LPSD_OP_NONE, LPSD_OP_ACT, LPSD_OP_RD, LPSD_OP_WR, LPSD_OP_PRE, LPSD_OP_REF,
    LPSD_OP_MRS, LPSD_OP_BST
  } lpsd_op_t;

  typedef enum logic [2:0] {
    LPSD_RUN, LPSD_PRE_PD, LPSD_ACT_PD, LPSD_SUSPEND, LPSD_SELF_REF, LPSD_DEEP_PD
  } lpsd_pwr_t;

  // Command pins as they arrive from the controller.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } lpsd_cmd_pins_t;

  // One decoded command with its address fields.
  typedef struct packed {
    lpsd_op_t op;
    logic [LPSD_BANKS-1:0] banks;
    logic [LPSD_ADDR_W-1:0] addr;
    logic auto_pre;
  } lpsd_cmd_t;
endpackage
